// ===== hw/ext_bus_pkg.sv
// constants shared by the external bus strobe and port pin logic
package ext_bus_pkg;
    localparam int        PHASE_W       = 4;
    localparam logic [3:0] PH_FIRST     = 4'h0;
    localparam logic [3:0] PH_HALF      = 4'h6;
    localparam logic [3:0] PH_LAST      = 4'hB;
    localparam logic [3:0] PH_LAST_X2   = 4'hA;
    localparam logic [3:0] HP_LAST      = 4'h5;
    localparam logic [3:0] HP_LAST_X2   = 4'h4;
    localparam logic [3:0] STEP_STD     = 4'h1;
    localparam logic [3:0] STEP_X2      = 4'h2;
    localparam logic [3:0] ALE_HP_END   = 4'h2;
    localparam logic [3:0] PROGRAM_STORE_STROBE_HP_BEG  = 4'h3;
    localparam logic [3:0] STRB_BEG     = 4'h6;
    localparam logic [3:0] STRB_END     = 4'hA;
    localparam int        PC_W          = 16;
    localparam logic [15:0] PC_EXT_BASE = 16'h8000;
    localparam int        RST_HOLD_MC   = 2;
    localparam logic [7:0] LATCH8_RST   = 8'hFF;
    localparam logic [1:0] LATCH2_RST   = 2'h3;
    localparam logic [7:0] DRIVE_ALL    = 8'hFF;
    localparam logic [7:0] DRIVE_NONE   = 8'h00;
    localparam int        P3_RXD        = 0;
    localparam int        P3_TXD        = 1;
    localparam int        P3_IRQ0       = 2;
    localparam int        P3_IRQ1       = 3;
    localparam int        P3_CNT0       = 4;
    localparam int        P3_CNT1       = 5;
    localparam int        P3_WR         = 6;
    localparam int        P3_RD         = 7;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_PEND = 2'b01,
        ACC_RUN  = 2'b10
    } acc_state_e;
endpackage

// ===== hw/mc_phase_gen.sv
// machine cycle phase counter, twelve or six oscillator periods
`timescale 1ns/10ps
`default_nettype none
module mc_phase_gen (
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           double_speed_mode,
    output logic [ext_bus_pkg::PHASE_W-1:0]     phase_ff,
    output logic [ext_bus_pkg::PHASE_W-1:0]     half_phase,
    output logic                                mc_last
);
    import ext_bus_pkg::*;

    logic [PHASE_W-1:0] nxt_phase;
    logic [PHASE_W-1:0] step;

    // double speed walks the same twelve phases two at a time
    assign step       = double_speed_mode ? STEP_X2 : STEP_STD;
    assign mc_last    = double_speed_mode ? (phase_ff >= PH_LAST_X2) : (phase_ff == PH_LAST);
    assign half_phase = (phase_ff >= PH_HALF) ? phase_ff - PH_HALF : phase_ff;
    assign nxt_phase  = mc_last ? PH_FIRST : phase_ff + step;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_ff <= PH_FIRST;
        end else begin
            phase_ff <= nxt_phase;
        end
    end
endmodule // mc_phase_gen
`default_nettype wire

// ===== hw/ext_bus_ctrl.sv
// external bus strobes, address/data ports and port three/four pins
//
// Behaviour
// - port three: eight quasi-bidirectional lines, latch one lets pin be read
// - bit 0 is serial receive input, or serial data line in sync mode
// - bit 1 is serial transmit data, or shift clock in sync mode
// - bits 2 and 3 are external interrupts and timer gate inputs
// - bits 4 and 5 are timer zero and one count inputs
// - bit 6 drives the external data write strobe
// - bit 7 drives the external data read strobe
// - port four: two quasi-bidirectional lines with pull-ups
// - reset pin high for two machine cycles resets the device
// - address latch pulse lets outside logic capture low address
// - latch pulse every six periods, three in double speed, one omitted per data access
// - software may stop latch pulses while running internal flash
// - program-store strobe asserts twice per machine cycle on external fetch
// - two program-store strobes are skipped per external data access
// - program-store strobe stays idle on internal fetch
// - access pin high: internal below 8000H, external above
// - access pin low: every fetch external
// - port zero multiplexes low address and data
// - port two gives high address on external fetch and pointer data access
// - port two keeps its latch on eight-bit indirect data access
// - reset sets all port latches to one
`timescale 1ns/10ps
`default_nettype none
module ext_bus_ctrl #(
    parameter int RST_HOLD = ext_bus_pkg::RST_HOLD_MC
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        reset_pin,
    output logic                             device_reset_ff,
    input  wire logic                        double_speed_mode,
    input  wire logic                        external_fetch_select,
    input  wire logic                        ale_disable,
    input  wire logic [ext_bus_pkg::PC_W-1:0] pc,
    output logic [7:0]                       fetch_data_ff,
    output logic                             fetch_valid_ff,
    input  wire logic                        xdata_req,
    input  wire logic                        xdata_wr,
    input  wire logic                        xdata_use_data_pointer_pair,
    input  wire logic [ext_bus_pkg::PC_W-1:0] xdata_addr,
    input  wire logic [7:0]                  xdata_wdata,
    output logic [7:0]                       xdata_rdata_ff,
    output logic                             xdata_done_ff,
    input  wire logic                        port_zero_wr,
    input  wire logic [7:0]                  port_zero_din,
    input  wire logic                        high_addr_wr,
    input  wire logic [7:0]                  high_addr_din,
    input  wire logic                        port_three_wr,
    input  wire logic [7:0]                  port_three_din,
    input  wire logic                        port_four_wr,
    input  wire logic [1:0]                  port_four_din,
    output logic [7:0]                       port_zero_latch_ff,
    output logic [7:0]                       high_address_port_latch_ff,
    output logic [7:0]                       port_three_latch_ff,
    output logic [1:0]                       port_four_latch_ff,
    input  wire logic                        serial_sync_mode,
    input  wire logic                        serial_tx_enable,
    input  wire logic                        serial_tx_data,
    input  wire logic                        serial_sync_data_out,
    output logic                             serial_rx_data_ff,
    output logic                             ext_irq_zero_pin_ff,
    output logic                             ext_irq_one_pin_ff,
    output logic                             counter_zero_input_ff,
    output logic                             counter_one_input_ff,
    output logic                             address_latch_ff,
    output logic                             program_store_strobe_n_ff,
    input  wire logic [7:0]                  p0_pin_in,
    output logic [7:0]                       p0_pin_out_ff,
    output logic [7:0]                       p0_pin_oe_ff,
    input  wire logic [7:0]                  p2_pin_in,
    output logic [7:0]                       p2_pin_out_ff,
    output logic [7:0]                       p2_pin_oe_ff,
    input  wire logic [7:0]                  p3_pin_in,
    output logic [7:0]                       p3_pin_out_ff,
    output logic [7:0]                       p3_pin_oe_ff,
    output logic [7:0]                       p3_pin_ff,
    input  wire logic [1:0]                  p4_pin_in,
    output logic [1:0]                       p4_pin_out_ff,
    output logic [1:0]                       p4_pin_oe_ff,
    output logic [1:0]                       p4_pin_ff
);
    import ext_bus_pkg::*;

    if (RST_HOLD < 1 || RST_HOLD > 3) begin : g_bad_hold
        $error("RST_HOLD must be 1 to 3 machine cycles");
    end

    logic [PHASE_W-1:0] phase_ff;
    logic [PHASE_W-1:0] half_phase;
    logic               mc_last;

    mc_phase_gen u_phase (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .double_speed_mode (double_speed_mode),
        .phase_ff          (phase_ff),
        .half_phase        (half_phase),
        .mc_last           (mc_last)
    );

    // data access request, held until the next machine cycle boundary
    acc_state_e  acc_state_ff;
    acc_state_e  nxt_acc_state;
    logic        acc_wr_ff;
    logic        acc_data_pointer_pair_ff;
    logic [15:0] acc_addr_ff;
    logic [7:0]  acc_wdata_ff;
    logic [1:0]  rst_cnt_ff;
    logic [1:0]  nxt_rst_cnt;

    wire acc_idle  = (acc_state_ff == ACC_IDLE);
    wire acc_run   = (acc_state_ff == ACC_RUN);
    wire take_req  = acc_idle && xdata_req;
    wire acc_high  = acc_run && (phase_ff >= PH_HALF);

    always_comb begin
        case (acc_state_ff)
            ACC_IDLE: nxt_acc_state = xdata_req ? ACC_PEND : ACC_IDLE;
            ACC_PEND: nxt_acc_state = mc_last ? ACC_RUN : ACC_PEND;
            ACC_RUN:  nxt_acc_state = mc_last ? ACC_IDLE : ACC_RUN;
            default:  nxt_acc_state = ACC_IDLE;
        endcase
    end

    // fetch source select
    wire ext_fetch   = !external_fetch_select || (pc >= PC_EXT_BASE);
    wire fetch_cycle = ext_fetch && !acc_run;

    // latch pulse in the first two periods of each half cycle, only the first period in double speed
    wire ale_sw_off  = ale_disable && external_fetch_select && !ext_fetch && !acc_run;
    wire nxt_ale     = (half_phase < ALE_HP_END) && !acc_high && !ale_sw_off;
    // strobe low in the back half of each half cycle, none in a data access
    wire nxt_program_store_strobe_n  = !(fetch_cycle && (half_phase >= PROGRAM_STORE_STROBE_HP_BEG));

    // read/write strobe window inside the access cycle
    wire strobe      = acc_run && (phase_ff >= STRB_BEG) && (phase_ff <= STRB_END);
    wire nxt_rd_n    = !(strobe && !acc_wr_ff);
    wire nxt_wr_n    = !(strobe && acc_wr_ff);

    // port zero: low address, then write data or float for read
    wire p0_addr_drv = acc_run ? (phase_ff < PH_HALF) : (fetch_cycle && (half_phase < PROGRAM_STORE_STROBE_HP_BEG));
    wire p0_data_drv = acc_high && acc_wr_ff;
    wire p0_bus_mode = acc_run || ext_fetch;
    wire [7:0] p0_addr    = acc_run ? acc_addr_ff[7:0] : pc[7:0];
    wire [7:0] nxt_p0_out = p0_bus_mode ? (p0_data_drv ? acc_wdata_ff : p0_addr) : port_zero_latch_ff;
    // open drain outside bus cycles: only a zero is driven
    wire [7:0] nxt_p0_oe  = p0_bus_mode ? ((p0_addr_drv || p0_data_drv) ? DRIVE_ALL : DRIVE_NONE)
                                        : ~port_zero_latch_ff;

    // port two: high address, or its own latch for indirect access
    wire p2_addr_mode     = acc_run ? acc_data_pointer_pair_ff : ext_fetch;
    wire [7:0] p2_addr    = acc_run ? acc_addr_ff[15:8] : pc[15:8];
    wire [7:0] nxt_p2_out = p2_addr_mode ? p2_addr : high_address_port_latch_ff;
    wire [7:0] nxt_p2_oe  = p2_addr_mode ? DRIVE_ALL : ~high_address_port_latch_ff;

    // port three alternate outputs; input-only functions leave a one
    logic [7:0] p3_alt;
    logic [7:0] nxt_p3_out;
    genvar gi;
    for (gi = 0; gi < 8; gi++) begin : g_p3
        if (gi == P3_RXD) begin : g_rxd
            assign p3_alt[gi] = serial_sync_mode ? serial_sync_data_out : 1'b1;
        end else if (gi == P3_RD) begin : g_rd
            assign p3_alt[gi] = nxt_rd_n;
        end else begin : g_in
            assign p3_alt[gi] = 1'b1;
        end
        if (gi == P3_TXD) begin : g_txd
            // transmit overrides the latch while the serial unit owns it
            assign nxt_p3_out[gi] = serial_tx_enable ? serial_tx_data : port_three_latch_ff[gi];
        end else if (gi == P3_WR) begin : g_wr
            // write strobe works whatever the latch holds
            assign nxt_p3_out[gi] = acc_run ? nxt_wr_n : port_three_latch_ff[gi];
        end else begin : g_and
            assign nxt_p3_out[gi] = port_three_latch_ff[gi] & p3_alt[gi];
        end
    end

    // reset pin counted in whole machine cycles
    assign nxt_rst_cnt = !reset_pin ? 2'h0
                       : (mc_last && (rst_cnt_ff < RST_HOLD[1:0])) ? rst_cnt_ff + 2'h1 : rst_cnt_ff;
    wire latch_rst = device_reset_ff;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_cnt_ff      <= 2'h0;
            device_reset_ff <= 1'b0;
        end else begin
            rst_cnt_ff      <= nxt_rst_cnt;
            device_reset_ff <= reset_pin && (rst_cnt_ff == RST_HOLD[1:0]);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_state_ff <= ACC_IDLE;
            acc_wr_ff    <= 1'b0;
            acc_data_pointer_pair_ff  <= 1'b0;
            acc_addr_ff  <= 16'h0000;
            acc_wdata_ff <= 8'h00;
        end else begin
            acc_state_ff <= nxt_acc_state;
            if (take_req) begin
                acc_wr_ff    <= xdata_wr;
                acc_data_pointer_pair_ff  <= xdata_use_data_pointer_pair;
                acc_addr_ff  <= xdata_addr;
                acc_wdata_ff <= xdata_wdata;
            end
        end
    end

    // port latches, set to all ones by either reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_zero_latch_ff         <= LATCH8_RST;
            high_address_port_latch_ff <= LATCH8_RST;
            port_three_latch_ff        <= LATCH8_RST;
            port_four_latch_ff         <= LATCH2_RST;
        end else if (latch_rst) begin
            port_zero_latch_ff         <= LATCH8_RST;
            high_address_port_latch_ff <= LATCH8_RST;
            port_three_latch_ff        <= LATCH8_RST;
            port_four_latch_ff         <= LATCH2_RST;
        end else begin
            if (port_zero_wr)  port_zero_latch_ff         <= port_zero_din;
            if (high_addr_wr)  high_address_port_latch_ff <= high_addr_din;
            if (port_three_wr) port_three_latch_ff        <= port_three_din;
            if (port_four_wr)  port_four_latch_ff         <= port_four_din;
        end
    end

    // strobes and pins, all registered
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            address_latch_ff          <= 1'b0;
            program_store_strobe_n_ff <= 1'b1;
            p0_pin_out_ff             <= LATCH8_RST;
            p0_pin_oe_ff              <= DRIVE_NONE;
            p2_pin_out_ff             <= LATCH8_RST;
            p2_pin_oe_ff              <= DRIVE_NONE;
            p3_pin_out_ff             <= LATCH8_RST;
            p3_pin_oe_ff              <= DRIVE_NONE;
            p4_pin_out_ff             <= LATCH2_RST;
            p4_pin_oe_ff              <= 2'h0;
        end else begin
            address_latch_ff          <= nxt_ale;
            program_store_strobe_n_ff <= nxt_program_store_strobe_n;
            p0_pin_out_ff             <= nxt_p0_out;
            p0_pin_oe_ff              <= nxt_p0_oe;
            p2_pin_out_ff             <= nxt_p2_out;
            p2_pin_oe_ff              <= nxt_p2_oe;
            p3_pin_out_ff             <= nxt_p3_out;
            p3_pin_oe_ff              <= ~nxt_p3_out;
            p4_pin_out_ff             <= port_four_latch_ff;
            p4_pin_oe_ff              <= ~port_four_latch_ff;
        end
    end

    // pin reads and alternate inputs; one stage of sampling
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            p3_pin_ff             <= LATCH8_RST;
            p4_pin_ff             <= LATCH2_RST;
            serial_rx_data_ff     <= 1'b1;
            ext_irq_zero_pin_ff   <= 1'b1;
            ext_irq_one_pin_ff    <= 1'b1;
            counter_zero_input_ff <= 1'b1;
            counter_one_input_ff  <= 1'b1;
        end else begin
            p3_pin_ff             <= p3_pin_in;
            p4_pin_ff             <= p4_pin_in;
            serial_rx_data_ff     <= p3_pin_in[P3_RXD];
            ext_irq_zero_pin_ff   <= p3_pin_in[P3_IRQ0];
            ext_irq_one_pin_ff    <= p3_pin_in[P3_IRQ1];
            counter_zero_input_ff <= p3_pin_in[P3_CNT0];
            counter_one_input_ff  <= p3_pin_in[P3_CNT1];
        end
    end

    // fetched byte taken while the strobe is still low
    // last clock of a strobe: in double speed the strobe is only one clock wide
    wire fetch_take = !program_store_strobe_n_ff && nxt_program_store_strobe_n;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fetch_data_ff  <= 8'h00;
            fetch_valid_ff <= 1'b0;
            xdata_rdata_ff <= 8'h00;
            xdata_done_ff  <= 1'b0;
        end else begin
            fetch_valid_ff <= fetch_take;
            if (fetch_take) fetch_data_ff <= p0_pin_in;
            xdata_done_ff  <= acc_run && mc_last;
            if (acc_run && mc_last && !acc_wr_ff) xdata_rdata_ff <= p0_pin_in;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_req_taken;
        take_req;
    endsequence
    sequence s_done;
        xdata_done_ff;
    endsequence

    property p_program_store_strobe_internal;
        !$past(ext_fetch) |-> program_store_strobe_n_ff;
    endproperty
    a_program_store_strobe_internal: assert property (p_program_store_strobe_internal) else $error("strobe on internal fetch");

    property p_program_store_strobe_skip;
        $past(acc_run) |-> program_store_strobe_n_ff;
    endproperty
    a_program_store_strobe_skip: assert property (p_program_store_strobe_skip) else $error("strobe during data access");

    property p_ale_skip;
        $past(acc_high) |-> !address_latch_ff;
    endproperty
    a_ale_skip: assert property (p_ale_skip) else $error("latch pulse in data access");

    property p_ale_sw_off;
        $past(ale_sw_off) |-> !address_latch_ff;
    endproperty
    a_ale_sw_off: assert property (p_ale_sw_off) else $error("latch pulse while disabled");

    property p_ale_width;
        $rose(address_latch_ff) && !double_speed_mode && $past(!double_speed_mode, 2)
            |-> address_latch_ff [*2] ##1 !address_latch_ff;
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch pulse not two periods");

    property p_fetch_sel;
        $fell(program_store_strobe_n_ff) |-> $past(!external_fetch_select || pc >= PC_EXT_BASE);
    endproperty
    a_fetch_sel: assert property (p_fetch_sel) else $error("external fetch below boundary");

    property p_access_done;
        s_req_taken |-> ##[8:25] s_done;
    endproperty
    a_access_done: assert property (p_access_done) else $error("data access did not finish");

    property p_wr_data;
        $past(strobe && acc_wr_ff) |-> !p3_pin_out_ff[P3_WR] && (p0_pin_oe_ff == DRIVE_ALL);
    endproperty
    a_wr_data: assert property (p_wr_data) else $error("write strobe without data");

    property p_p2_indirect;
        $past(acc_run && !acc_data_pointer_pair_ff) |-> p2_pin_out_ff == $past(high_address_port_latch_ff);
    endproperty
    a_p2_indirect: assert property (p_p2_indirect) else $error("port two left its latch");

    property p_latch_reset;
        device_reset_ff |=> (port_three_latch_ff == LATCH8_RST) && (port_four_latch_ff == LATCH2_RST);
    endproperty
    a_latch_reset: assert property (p_latch_reset) else $error("latches not set by reset");

    property p_reset_release;
        !reset_pin |=> !device_reset_ff;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("reset held without pin");
endmodule // ext_bus_ctrl
`default_nettype wire

// ===== verif/ext_mem_model.sv
// external program/data memory with address latch on the multiplexed bus
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
    input  wire logic       clk,
    input  wire logic       ale,
    input  wire logic       ps_n,
    input  wire logic [7:0] strobes,
    input  wire logic [7:0] bus_out,
    input  wire logic [7:0] bus_oe,
    input  wire logic [7:0] hi_addr,
    output logic [7:0]      bus_in
);
    logic [7:0] lo_ff, hi_ff, last_ff, wr_ff;
    logic [7:0] mem [0:255];
    // released bus shows the inverse of its last level, never a stale byte
    wire logic [7:0] drv = !ps_n ? (lo_ff ^ hi_ff) : !strobes[7] ? mem[lo_ff] : ~last_ff;
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & drv);
    always_ff @(posedge clk) begin
        last_ff <= bus_in;
        wr_ff <= strobes;
        if (ale) begin
            lo_ff <= bus_in;
            hi_ff <= hi_addr;
        end
        if (!wr_ff[6] && strobes[6]) mem[lo_ff] <= bus_in;
    end
endmodule // ext_mem_model
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the external bus strobe and port pin block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk = 0, sys_rst = 1, reset_pin = 0, double_speed_mode = 0, external_fetch_select = 1;
    logic ale_disable = 0, xdata_req = 0, xdata_wr = 0, xdata_use_data_pointer_pair = 1, port_three_wr = 0;
    logic port_four_wr = 0, serial_tx_enable = 0, serial_tx_data = 1, ale_q, ps_q;
    logic serial_sync_mode = 0, serial_sync_data_out = 1;
    logic [15:0] pc = 16'h0100, xdata_addr = 16'h0042;
    logic [7:0] xdata_wdata = 8'h00, port_three_din = 8'hFF, pin3_ext = 8'hFF;
    logic [1:0] port_four_din = 2'h3, port_four_latch_ff, p4_pin_out_ff, p4_pin_ff, p4_pin_oe_ff;
    logic device_reset_ff, fetch_valid_ff, xdata_done_ff, address_latch_ff, program_store_strobe_n_ff;
    logic serial_rx_data_ff, ext_irq_zero_pin_ff, ext_irq_one_pin_ff, counter_zero_input_ff, counter_one_input_ff;
    logic [7:0] fetch_data_ff, xdata_rdata_ff, port_three_latch_ff, p0_pin_in, p0_pin_out_ff, p0_pin_oe_ff;
    logic [7:0] p2_pin_out_ff, p3_pin_out_ff, p3_pin_ff, p3_pin_oe_ff;
    wire logic [7:0] pin3_lvl = p3_pin_out_ff & pin3_ext;
    int err_total = 0, num_checks = 0, ale_n = 0, ps_n = 0, dn_n = 0;
    ext_bus_ctrl ext_bus_ctrl_inst (.clk, .sys_rst, .reset_pin, .device_reset_ff, .double_speed_mode,
        .external_fetch_select, .ale_disable, .pc, .fetch_data_ff, .fetch_valid_ff, .xdata_req, .xdata_wr,
        .xdata_use_data_pointer_pair, .xdata_addr, .xdata_wdata, .xdata_rdata_ff, .xdata_done_ff, .port_zero_wr(1'b0),
        .port_zero_din(xdata_wdata), .high_addr_wr(1'b0), .high_addr_din(xdata_wdata), .port_three_wr,
        .port_three_din, .port_four_wr, .port_four_din, .port_zero_latch_ff(), .high_address_port_latch_ff(),
        .port_three_latch_ff, .port_four_latch_ff, .serial_sync_mode, .serial_tx_enable, .serial_tx_data,
        .serial_sync_data_out, .serial_rx_data_ff, .ext_irq_zero_pin_ff, .ext_irq_one_pin_ff,
        .counter_zero_input_ff, .counter_one_input_ff, .address_latch_ff, .program_store_strobe_n_ff,
        .p0_pin_in, .p0_pin_out_ff, .p0_pin_oe_ff, .p2_pin_in(p2_pin_out_ff), .p2_pin_out_ff, .p2_pin_oe_ff(),
        .p3_pin_in(pin3_lvl), .p3_pin_out_ff, .p3_pin_oe_ff, .p3_pin_ff, .p4_pin_in(p4_pin_out_ff),
        .p4_pin_out_ff, .p4_pin_oe_ff, .p4_pin_ff);
    ext_mem_model ext_mem_model_inst (.clk, .ale(address_latch_ff), .ps_n(program_store_strobe_n_ff),
        .strobes(pin3_lvl), .bus_out(p0_pin_out_ff), .bus_oe(p0_pin_oe_ff), .hi_addr(p2_pin_out_ff),
        .bus_in(p0_pin_in));
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        ale_q <= address_latch_ff;
        ps_q <= program_store_strobe_n_ff;
        if (address_latch_ff && !ale_q) ale_n++;
        if (!program_store_strobe_n_ff && ps_q) ps_n++;
        if (xdata_done_ff) dn_n++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // settle first: the machine cycle under way at a mode change runs partly in each mode
    task automatic count(input int s, input int n, input int na, input int np);
        repeat (s) @(negedge clk);
        ale_n = 0;
        ps_n = 0;
        repeat (n) @(negedge clk);
        chk(ale_n, na);
        chk(ps_n, np);
    endtask
    task automatic fetch_test;
        count(12, 24, 4, 0);
        @(posedge clk) pc <= 16'h8123;
        count(12, 24, 4, 4);
        for (int i = 0; i < 30 && fetch_valid_ff !== 1'b1; i++) @(negedge clk);
        chk(fetch_data_ff, 16'h00A2);
        @(posedge clk) double_speed_mode <= 1;
        count(12, 24, 8, 8);
        @(posedge clk) external_fetch_select <= 0;
        pc <= 16'h0100;
        count(12, 24, 8, 8);
        @(posedge clk) external_fetch_select <= 1;
        ale_disable <= 1;
        double_speed_mode <= 0;
        count(12, 24, 0, 0);
        @(posedge clk) ale_disable <= 0;
        pc <= 16'h8123;
        count(12, 24, 4, 4);
    endtask
    // a 36-clock window over one data access holds five latch pulses, four fetch strobes and one done
    task automatic xdata(input logic wr, input logic [7:0] d, input logic dp);
        @(posedge clk) xdata_req <= 1;
        xdata_wr <= wr;
        xdata_use_data_pointer_pair <= dp;
        xdata_wdata <= d;
        @(negedge clk) dn_n = 0;
        ale_n = 0;
        ps_n = 0;
        @(posedge clk) xdata_req <= 0;
        repeat (36) @(negedge clk);
        chk(ale_n, 5);
        chk(ps_n, 4);
        chk(dn_n, 1);
    endtask
    task automatic port_test;
        @(posedge clk) pin3_ext <= 8'hC2;
        port_four_wr <= 1;
        port_four_din <= 2'h2;
        @(posedge clk) port_four_wr <= 0;
        repeat (3) @(negedge clk);
        chk({ext_irq_zero_pin_ff, ext_irq_one_pin_ff, counter_zero_input_ff, counter_one_input_ff}, 0);
        chk({serial_rx_data_ff, p3_pin_ff}, 16'h00C2);
        chk({port_four_latch_ff, p4_pin_ff}, 16'h000A);
        @(posedge clk) pin3_ext <= 8'hFF;
        serial_tx_enable <= 1;
        serial_tx_data <= 0;
        serial_sync_mode <= 1;
        repeat (3) @(negedge clk);
        chk({ext_irq_zero_pin_ff, ext_irq_one_pin_ff, counter_zero_input_ff, counter_one_input_ff}, 16'h000F);
        chk({serial_rx_data_ff, p3_pin_out_ff[1]}, 16'h0002);
        chk({p3_pin_oe_ff, p4_pin_oe_ff}, 16'h0009);
        @(posedge clk) serial_sync_data_out <= 0;
        repeat (3) @(negedge clk);
        chk({serial_rx_data_ff, p3_pin_out_ff[0]}, 16'h0000);
    endtask
    task automatic rst_pin_test;
        @(posedge clk) port_three_wr <= 1;
        port_three_din <= 8'h00;
        @(posedge clk) port_three_wr <= 0;
        reset_pin <= 1;
        repeat (12) @(negedge clk);
        chk(device_reset_ff, 0);
        repeat (26) @(negedge clk);
        chk({device_reset_ff, port_three_latch_ff}, 16'h01FF);
        @(posedge clk) reset_pin <= 0;
        repeat (3) @(negedge clk);
        chk(device_reset_ff, 0);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 0;
        fetch_test;
        xdata(1, 8'hA5, 1);
        chk(ext_mem_model_inst.mem[8'h42], 16'h00A5);
        xdata(0, 8'h00, 0);
        chk(xdata_rdata_ff, 16'h00A5);
        rst_pin_test;
        port_test;
        print_verdict;
    end
    initial begin
        #(5 * 3000);
        err_total++;
        print_verdict;
    end
endmodule // testbench
`default_nettype wire
